// file: rtl/hcbc_pkg.sv
package hcbc_pkg;
  // timing figures in their own units
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CHOP_SETTLE_US  = 160;
  localparam int unsigned RESTART_MS      = 100;
  localparam int unsigned PWM_FREQ_HZ     = 40_000;
  // derived cycle counts (PWM period rounds up)
  localparam int unsigned CHOP_SETTLE_CYC = (CHOP_SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RESTART_CYC     = (RESTART_MS * (CLK_HZ / 1_000));
  localparam int unsigned STARTUP_CYC     = CHOP_SETTLE_CYC + RESTART_CYC;
  localparam int unsigned PWM_PERIOD_CYC  = (CLK_HZ + PWM_FREQ_HZ - 1) / PWM_FREQ_HZ;
  localparam int unsigned PWM_W           = 8;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned SLEW_W          = 4;
  // duty in percent, indexed by variant and selection
  localparam logic [6:0] DUTY_LO_LOW   = 7'h38; // 56
  localparam logic [6:0] DUTY_LO_FLOAT = 7'h3E; // 62
  localparam logic [6:0] DUTY_LO_HIGH  = 7'h44; // 68
  localparam logic [6:0] DUTY_HI_LOW   = 7'h47; // 71
  localparam logic [6:0] DUTY_HI_FLOAT = 7'h50; // 80
  localparam logic [6:0] DUTY_HI_HIGH  = 7'h59; // 89
  localparam logic [6:0] PCT_FULL      = 7'h64; // 100

  typedef enum logic [1:0] {
    HCBC_SEL_LOW   = 2'b00,
    HCBC_SEL_FLOAT = 2'b01,
    HCBC_SEL_HIGH  = 2'b10
  } hcbc_sel_t;

  typedef enum logic [2:0] {
    HCBC_ST_START = 3'b000,
    HCBC_ST_RUN   = 3'b001,
    HCBC_ST_BRAKE = 3'b010,
    HCBC_ST_SLEEP = 3'b011,
    HCBC_ST_KICK  = 3'b100
  } hcbc_state_t;
endpackage : hcbc_pkg

// file: rtl/hcbc_bridge_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: bridge polarity follows field with hysteresis
// R2: host pulls sleep low to brake, sleep
// R3: brake inverts polarity for fixed interval
// R4: after brake, bridge off, logic idle
// R5: stall triggers forced commutation kick
// R6: above speed threshold, PWM gates drive
// R7: duty select low, floating, high
// R8: sleep tied high runs straight from power-up
// R9: polarity edges are slew-stepped, never abrupt
// R10: over-temperature disables bridge until cleared
// R11: outputs invalid until settle and restart delays
// R12: duties 56/62/68 or 71/80/89 percent
// R13: stall timeout, brake interval are parameters
// R14: speed from clock count between Hall edges
module hcbc_bridge_ctrl #(
  parameter int unsigned HIGH_DUTY_VARIANT = 0,
  parameter int unsigned STARTUP_CYCLES    = hcbc_pkg::STARTUP_CYC,
  parameter int unsigned BRAKE_CYCLES      = 200_000,
  parameter int unsigned STALL_CYCLES      = 2_000_000,
  parameter int unsigned KICK_CYCLES       = 100_000,
  parameter int unsigned SPEED_TH_CYCLES   = 20_000
) (
  // clock and power-up reset
  input  wire logic clk,
  input  wire logic arst_n,
  // hall comparator levels
  input  wire logic field_operate_point,
  input  wire logic field_release_point,
  // host and protection inputs
  input  wire logic sleep_n,
  input  wire logic duty_sel_low,
  input  wire logic duty_sel_high,
  input  wire logic over_temp,
  // bridge drive and status
  output logic      bridge_out_a,
  output logic      bridge_out_b,
  output logic      bridge_en,
  output logic      out_valid,
  output logic      asleep
);
  localparam int unsigned CW = hcbc_pkg::CNT_W;
  localparam int unsigned PW = hcbc_pkg::PWM_W;
  localparam logic [CW-1:0] START_C = CW'(STARTUP_CYCLES - 1);
  localparam logic [CW-1:0] BRAKE_C = CW'(BRAKE_CYCLES - 1);
  localparam logic [CW-1:0] STALL_C = CW'(STALL_CYCLES - 1);
  localparam logic [CW-1:0] KICK_C  = CW'(KICK_CYCLES - 1);
  localparam logic [CW-1:0] SPEED_C = CW'(SPEED_TH_CYCLES);
  localparam logic [PW-1:0] PWM_TOP = PW'(hcbc_pkg::PWM_PERIOD_CYC - 1);

  // two-flop synchronisers for all pin inputs
  localparam int unsigned NIN = 6;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  assign pin_raw = {over_temp, duty_sel_high, duty_sel_low, sleep_n, field_release_point, field_operate_point};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  logic op_s, rp_s, slp_n_s, sel_lo_s, sel_hi_s, ot_s;
  assign {ot_s, sel_hi_s, sel_lo_s, slp_n_s, rp_s, op_s} = sync2_r;

  // state
  hcbc_pkg::hcbc_state_t st_r, st_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt;
  logic [CW-1:0] per_r, per_nxt;
  logic [CW-1:0] stall_r, stall_nxt;
  logic          pole_r, pole_nxt;
  logic          fast_r, fast_nxt;
  logic [PW-1:0] pwm_r, pwm_nxt;
  logic [hcbc_pkg::SLEW_W-1:0] slew_r, slew_nxt;
  logic          a_r, a_nxt, b_r, b_nxt, en_r, en_nxt, val_r, val_nxt, slp_r, slp_nxt;

  logic          pole_new;
  logic          hall_edge;
  logic [6:0]    duty_pct;
  logic [PW+6:0] duty_cmp;
  logic          pwm_on;
  logic          drive_pol;
  logic          drive_on;
  logic          pwm_gate;

  always_comb begin
    // field below release -> pole 0, above operate -> pole 1, else hold
    pole_new = pole_r; // [R1]
    if (op_s) pole_new = 1'b1; // [R1]
    else if (rp_s) pole_new = 1'b0; // [R1]
    hall_edge = (pole_new != pole_r);
    // lo wins if both straps read asserted
    if (HIGH_DUTY_VARIANT != 0) begin
      duty_pct = sel_lo_s ? hcbc_pkg::DUTY_HI_LOW
               : (sel_hi_s ? hcbc_pkg::DUTY_HI_HIGH : hcbc_pkg::DUTY_HI_FLOAT); // [R7] [R12]
    end else begin
      duty_pct = sel_lo_s ? hcbc_pkg::DUTY_LO_LOW
               : (sel_hi_s ? hcbc_pkg::DUTY_LO_HIGH : hcbc_pkg::DUTY_LO_FLOAT); // [R7] [R12]
    end
    duty_cmp = (PW+7)'(duty_pct) * (PW+7)'(hcbc_pkg::PWM_PERIOD_CYC);
    pwm_on   = ((PW+7)'(pwm_r) * (PW+7)'(hcbc_pkg::PCT_FULL)) < duty_cmp; // [R6]
  end

  always_comb begin
    st_nxt    = st_r;
    tmr_nxt   = tmr_r;
    per_nxt   = per_r;
    stall_nxt = stall_r;
    pole_nxt  = pole_new; // [R1]
    fast_nxt  = fast_r;
    pwm_nxt   = (pwm_r == PWM_TOP) ? '0 : pwm_r + 1'b1;
    drive_pol = pole_new;
    drive_on  = 1'b0;
    // speed measured as cycles between hall edges; saturates when slow
    if (hall_edge) begin
      fast_nxt = (per_r < SPEED_C); // [R14]
      per_nxt  = '0; // [R14]
    end else if (per_r != {CW{1'b1}}) begin
      per_nxt = per_r + 1'b1; // [R14]
      if (per_r >= SPEED_C) fast_nxt = 1'b0; // [R14]
    end
    case (st_r)
      hcbc_pkg::HCBC_ST_START: begin
        // sleep tied high simply finds slp_n_s high here
        tmr_nxt = tmr_r + 1'b1; // [R11]
        if (tmr_r >= START_C) begin
          tmr_nxt = '0;
          stall_nxt = '0;
          st_nxt  = slp_n_s ? hcbc_pkg::HCBC_ST_RUN : hcbc_pkg::HCBC_ST_SLEEP; // [R8] [R11]
        end
      end
      hcbc_pkg::HCBC_ST_RUN: begin
        drive_on = 1'b1;
        stall_nxt = hall_edge ? '0 : stall_r + 1'b1; // [R13]
        if (!slp_n_s) begin
          st_nxt  = hcbc_pkg::HCBC_ST_BRAKE; // [R2] [R3]
          tmr_nxt = '0;
          pole_nxt = pole_r; // freeze the polarity to invert
        end else if (stall_r >= STALL_C && !ot_s) begin
          st_nxt  = hcbc_pkg::HCBC_ST_KICK; // [R5] [R13]
          tmr_nxt = '0;
        end
      end
      hcbc_pkg::HCBC_ST_KICK: begin
        // forced commutation: drive the opposite pole to pull the rotor on
        drive_on  = 1'b1;
        drive_pol = ~pole_r; // [R5]
        pole_nxt  = pole_r;
        tmr_nxt   = tmr_r + 1'b1;
        if (!slp_n_s) begin
          st_nxt  = hcbc_pkg::HCBC_ST_BRAKE;
          tmr_nxt = '0;
        end else if (tmr_r >= KICK_C) begin
          st_nxt    = hcbc_pkg::HCBC_ST_RUN; // [R5]
          stall_nxt = '0;
          tmr_nxt   = '0;
        end
      end
      hcbc_pkg::HCBC_ST_BRAKE: begin
        drive_on  = 1'b1;
        drive_pol = ~pole_r; // [R3]
        pole_nxt  = pole_r;
        tmr_nxt   = tmr_r + 1'b1; // [R3] [R13]
        if (tmr_r >= BRAKE_C) begin
          st_nxt  = hcbc_pkg::HCBC_ST_SLEEP; // [R4]
          tmr_nxt = '0;
        end
      end
      hcbc_pkg::HCBC_ST_SLEEP: begin
        // counters frozen, pwm counter cleared, to keep activity down while asleep
        pwm_nxt  = '0; // [R4]
        per_nxt  = per_r;
        fast_nxt = 1'b0;
        if (slp_n_s) begin
          st_nxt    = hcbc_pkg::HCBC_ST_RUN; // [R2]
          stall_nxt = '0;
        end
      end
      default: begin
        st_nxt  = hcbc_pkg::HCBC_ST_START;
        tmr_nxt = '0;
      end
    endcase
    // pwm only in normal running above speed threshold; it gates the enable alone,
    // since re-arming the slew on every pwm edge would eat into the duty
    pwm_gate = !(st_r == hcbc_pkg::HCBC_ST_RUN && fast_r && !pwm_on); // [R6]
    if (ot_s) drive_on = 1'b0; // [R10]
    // slew: a polarity change passes through a dead off phase of SLEW steps
    // polarity keeps tracking the pole while the drive is off
    a_nxt    = a_r;
    b_nxt    = b_r;
    slew_nxt = slew_r;
    en_nxt   = 1'b0;
    if ((a_r != drive_pol) || (b_r == drive_pol)) begin
      slew_nxt = '1; // [R9]
      a_nxt    = drive_pol; // [R1]
      b_nxt    = ~drive_pol; // [R1]
    end else if (!drive_on) begin
      slew_nxt = '1; // [R9]
    end else if (slew_r != '0) begin
      slew_nxt = slew_r - 1'b1; // [R9]
    end else begin
      // no drive in the cycle that enters sleep
      en_nxt = pwm_gate && (st_nxt != hcbc_pkg::HCBC_ST_SLEEP); // [R4] [R6]
    end
    val_nxt = (st_nxt != hcbc_pkg::HCBC_ST_START); // [R11]
    slp_nxt = (st_nxt == hcbc_pkg::HCBC_ST_SLEEP); // [R4]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= hcbc_pkg::HCBC_ST_START;
      tmr_r   <= '0;
      per_r   <= '1;
      stall_r <= '0;
      pole_r  <= 1'b0;
      fast_r  <= 1'b0;
      pwm_r   <= '0;
      slew_r  <= '1;
      a_r     <= 1'b0;
      b_r     <= 1'b1;
      en_r    <= 1'b0;
      val_r   <= 1'b0;
      slp_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      per_r   <= per_nxt;
      stall_r <= stall_nxt;
      pole_r  <= pole_nxt;
      fast_r  <= fast_nxt;
      pwm_r   <= pwm_nxt;
      slew_r  <= slew_nxt;
      a_r     <= a_nxt;
      b_r     <= b_nxt;
      en_r    <= en_nxt;
      val_r   <= val_nxt;
      slp_r   <= slp_nxt;
    end
  end

  assign bridge_out_a = a_r;
  assign bridge_out_b = b_r;
  assign bridge_en    = en_r;
  assign out_valid    = val_r;
  assign asleep       = slp_r;
endmodule : hcbc_bridge_ctrl

// file: testbench/hcbc_bridge_ctrl_monitor.sv
`timescale 1ns/1ps
module hcbc_bridge_ctrl_monitor #(
  parameter int unsigned BRAKE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // inputs
  input wire logic field_operate_point,
  input wire logic field_release_point,
  input wire logic sleep_n,
  input wire logic over_temp,
  // outputs
  input wire logic bridge_out_a,
  input wire logic bridge_out_b,
  input wire logic bridge_en,
  input wire logic out_valid,
  input wire logic asleep
);
  localparam int B_LO = BRAKE_CYCLES - 4;
  localparam int B_HI = BRAKE_CYCLES + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence brake_req;
    $fell(sleep_n) && out_valid && !asleep;
  endsequence
  sequence brake_flip;
    ##[2:5] $changed(bridge_out_a);
  endsequence
  chk_bridge_compl: assert property (bridge_out_b != bridge_out_a)
    else $error("bridge outputs not complementary");
  chk_valid_gate: assert property (!out_valid |-> !bridge_en)
    else $error("drive before outputs valid");
  chk_op_pole: assert property ($rose(field_operate_point) && out_valid && sleep_n && !asleep
    |-> ##[2:4] bridge_out_a)
    else $error("no high polarity after operate point");
  chk_rp_pole: assert property ($rose(field_release_point) && !field_operate_point && out_valid && sleep_n
    && !asleep |-> ##[2:4] !bridge_out_a)
    else $error("no low polarity after release point");
  chk_temp_off: assert property (over_temp [*3] |=> !bridge_en)
    else $error("drive during over-temperature");
  chk_sleep_off: assert property (asleep |-> !bridge_en)
    else $error("drive while asleep");
  chk_dead_time: assert property ($changed(bridge_out_a) |-> !bridge_en [*8])
    else $error("abrupt polarity edge");
  chk_brake_seq: assert property (brake_req |-> brake_flip ##[B_LO:B_HI] asleep)
    else $error("brake sequence wrong");
endmodule : hcbc_bridge_ctrl_monitor
bind hcbc_bridge_ctrl hcbc_bridge_ctrl_monitor #(.BRAKE_CYCLES(BRAKE_CYCLES)) mon_u (.clk, .arst_n,
  .field_operate_point, .field_release_point, .sleep_n, .over_temp, .bridge_out_a, .bridge_out_b,
  .bridge_en, .out_valid, .asleep);

// file: testbench/hcbc_motor_model.sv
`timescale 1ns/1ps
module hcbc_motor_model (
  // motion
  input  wire logic        clk,
  input  wire logic        spin,
  input  wire logic [11:0] half,
  // hall levels
  output logic             field_operate_point,
  output logic             field_release_point
);
  int   cnt  = 0;
  logic pole = 1'b0;
  // a stopped rotor keeps its field, so stall needs no special case
  always @(posedge clk) begin
    if (spin) begin
      cnt <= (cnt >= half) ? 0 : cnt + 1;
      if (cnt == half) pole <= ~pole;
    end
  end
  // both low near a pole change: field inside the hysteresis band
  assign field_operate_point = pole && (cnt > 2);
  assign field_release_point = !pole && (cnt > 2);
endmodule : hcbc_motor_model

// file: testbench/hall_commutated_bridge_control_test.sv
`timescale 1ns/1ps
module hall_commutated_bridge_control_test;
  logic        clk, arst_n, sleep_n, sel_lo, sel_hi, over_temp, spin;
  logic        fop, frp, out_a, out_b, en, valid, asleep;
  logic [11:0] half;
  int          n_fail = 0, n_tests = 0, seed = 32'h8CD9, pole = 0, on;
  int          dty[3] = '{56, 62, 68};
  hcbc_bridge_ctrl #(.STARTUP_CYCLES(50), .BRAKE_CYCLES(20), .STALL_CYCLES(5000), .KICK_CYCLES(10),
    .SPEED_TH_CYCLES(2000)) dut_u (.clk, .arst_n, .field_operate_point(fop), .field_release_point(frp),
    .sleep_n, .duty_sel_low(sel_lo), .duty_sel_high(sel_hi), .over_temp, .bridge_out_a(out_a),
    .bridge_out_b(out_b), .bridge_en(en), .out_valid(valid), .asleep);
  hcbc_motor_model mot_u (.clk, .spin, .half, .field_operate_point(fop), .field_release_point(frp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp_cnt
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    arst_n = 1'b0; sleep_n = 1'b1; sel_lo = 1'b1; sel_hi = 1'b0; over_temp = 1'b0; spin = 1'b0;
    half = 12'h9C4;
    tick(1);
    cmp_bit(out_b, 1'b1);
    cmp_bit(valid, 1'b0);
    tick(5);
    arst_n = 1'b1;
    tick(60);
    cmp_bit(valid, 1'b1);
    cmp_bit(asleep, 1'b0);
    spin = 1'b1;
    repeat (3) begin
      @(posedge fop or posedge frp);
      pole = fop;
      tick(40);
      cmp_bit(out_a, pole[0]);
      cmp_bit(en, 1'b1);
    end
    over_temp = 1'b1;
    tick(5);
    cmp_bit(en, 1'b0);
    over_temp = 1'b0;
    tick(40);
    cmp_bit(en, 1'b1);
    $display("test polarity and over-temperature done");
    for (int s = 0; s < 3; s++) begin
      sel_lo = (s == 0);
      sel_hi = (s == 2);
      half = 12'(500 + $unsigned($random(seed)) % 100);
      repeat (3) @(posedge fop or posedge frp);
      tick(50);
      on = 0;
      repeat (hcbc_pkg::PWM_PERIOD_CYC) begin
        tick(1);
        on += (en === 1'b1);
      end
      cmp_cnt(on, dty[s] * hcbc_pkg::PWM_PERIOD_CYC / 100);
    end
    $display("test duty selection done");
    half = 12'h9C4;
    repeat (2) @(posedge fop or posedge frp);
    tick(40);
    spin = 1'b0;
    pole = out_a;
    for (on = 0; on < 6000 && out_a === pole[0]; on++) tick(1);
    cmp_bit(out_a, ~pole[0]);
    tick(30);
    cmp_bit(out_a, pole[0]);
    sleep_n = 1'b0;
    tick(6);
    cmp_bit(out_a, ~pole[0]);
    tick(30);
    cmp_bit(asleep, 1'b1);
    cmp_bit(en, 1'b0);
    sleep_n = 1'b1;
    tick(10);
    cmp_bit(asleep, 1'b0);
    $display("test stall, brake and sleep done");
    end_sim();
  end
  initial begin
    #(100 * 60000);
    n_fail++;
    end_sim();
  end
endmodule : hall_commutated_bridge_control_test
